/* File: fbm_pkg.sv */
`default_nettype none
package fbm_pkg;
   // ------------------------------------------------------------
   // Sizes
   // ------------------------------------------------------------
   localparam int NUM_WORDS = 10;
   localparam int MAP_SLOTS = 20;
   localparam logic [3:0] LAST_SLOT = 4'h9;
   localparam logic [4:0] IN_MAP_OFS = 5'h0a;
   localparam logic [15:0] UNUSED_ADDR = 16'h0000;

   // ------------------------------------------------------------
   // Configuration codes
   // ------------------------------------------------------------
   localparam logic [7:0] PROTO_FLEX = 8'h02;
   localparam logic [7:0] RT_READ = 8'h01;
   localparam logic [7:0] DO_INVERTER = 8'h01;
   localparam logic [7:0] PA_READ_VALUE = 8'h10;
   localparam logic [7:0] RSP_OK = 8'h01;
   localparam logic [7:0] RSP_FAIL = 8'h81;
   localparam logic [7:0] CHAN_SLOT = 8'h00;
   localparam logic [7:0] CHAN_INDEX = 8'h2f;
   localparam logic [15:0] OUT_MAP_PNU = 16'h0393;
   localparam logic [15:0] IN_MAP_PNU = 16'h0394;
   localparam logic [15:0] HDR_WORDS = 16'h0002;
   localparam logic [15:0] WORDS_PER_ADDR = 16'h0003;

   // ------------------------------------------------------------
   // Parameter number ranges
   // ------------------------------------------------------------
   localparam logic [15:0] BOARD_LO = 16'h037a;
   localparam logic [15:0] BOARD_HI = 16'h03e7;
   localparam logic [15:0] ELEM_MAX = 16'h03e7;
   localparam int NUM_GROUPS = 8;

   typedef enum logic [3:0] {
      GRP_NONE = 4'h0,
      GRP_BOARD = 4'h1,
      GRP_A = 4'h2,
      GRP_B = 4'h3,
      GRP_C = 4'h4,
      GRP_D = 4'h5,
      GRP_F = 4'h6,
      GRP_H = 4'h7,
      GRP_P = 4'h8,
      GRP_U = 4'h9
   } fbm_group_type;

   localparam logic [NUM_GROUPS-1:0][15:0] GROUP_BASE = {
      16'h5208, 16'h3e80, 16'h1f40, 16'h1770,
      16'h0fa0, 16'h0bb8, 16'h07d0, 16'h03e8};
   localparam logic [NUM_GROUPS-1:0][3:0] GROUP_CODE = {
      4'h9, 4'h8, 4'h7, 4'h6, 4'h5, 4'h4, 4'h3, 4'h2};

   // ------------------------------------------------------------
   // APB map
   // ------------------------------------------------------------
   localparam int APB_AW = 12;
   localparam logic [11:0] CTRL_OFS = 12'h000;
   localparam logic [11:0] STATUS_OFS = 12'h004;
   localparam logic [11:0] MAP_BASE = 12'h040;
   localparam logic [11:0] MAP_END = 12'h08c;
   localparam int PERM_BIT = 8;
   localparam int BUSY_BIT = 0;
   localparam int BLOCKED_BIT = 1;
   localparam int RUN_BIT = 2;
   localparam logic [7:0] PROTO_RESET = 8'h00;

   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   typedef logic [NUM_WORDS-1:0][15:0] fbm_words_type;
   typedef logic [MAP_SLOTS-1:0][15:0] fbm_map_type;

   typedef struct packed {
      logic write;
      logic [15:0] addr;
      logic [15:0] wdata;
   } fbm_mb_req_type;

   typedef struct packed {
      logic error;
      fbm_group_type group;
      logic [15:0] pnu;
      logic [9:0] element;
      logic [7:0] count;
      logic [15:0] index;
      logic [15:0] value;
   } fbm_pa_type;

   typedef struct packed {
      logic [7:0] rtype;
      logic [7:0] ref_id;
      logic [7:0] count;
   } fbm_rsp_type;
endpackage
`default_nettype wire

/* File: fbm_map_mem.sv */
`timescale 1ns/10ps
`default_nettype none
// Map slot storage; every read word comes out of a register
module fbm_map_mem #(
   parameter int SLOTS = fbm_pkg::MAP_SLOTS
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic wr_en,
   input wire logic [4:0] wr_idx,
   input wire logic [15:0] wr_data,
   output logic [SLOTS-1:0][15:0] map_q
);
   import fbm_pkg::*;
   logic [SLOTS-1:0][15:0] map_d;

   // Next contents
   always_comb begin
      map_d = map_q;
      if (wr_en) begin
         map_d[wr_idx] = wr_data;
      end
   end

   // Storage, all slots unused after reset
   always_ff @(posedge mclk) begin
      if (reset) begin
         map_q <= '0;
      end else begin
         map_q <= map_d;
      end
   end
endmodule
`default_nettype wire

/* File: fbm_pnu_decode.sv */
`timescale 1ns/10ps
`default_nettype none
// Parameter number to group and element
module fbm_pnu_decode (
   input wire logic [15:0] pnu,
   output fbm_pkg::fbm_group_type group,
   output logic [9:0] element
);
   import fbm_pkg::*;
   logic [15:0] diff;

   // Range lookup over the group base table
   always_comb begin
      group = GRP_NONE;
      element = '0;
      diff = '0;
      if (pnu >= BOARD_LO && pnu <= BOARD_HI) begin
         group = GRP_BOARD;
         element = pnu[9:0];
      end
      for (int i = 0; i < NUM_GROUPS; i++) begin
         diff = pnu - GROUP_BASE[i];
         if (pnu > GROUP_BASE[i] && diff <= ELEM_MAX) begin
            group = fbm_group_type'(GROUP_CODE[i]);
            element = diff[9:0];
         end
      end
   end
endmodule
`default_nettype wire

/* File: fbm_mapper.sv */
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Cyclic mapping only when protocol select is 2
// - Always ten output and ten input words
// - Output word k written to slot k address
// - Input word k read from slot 10+k address
// - Zero slot address takes no transfer
// - Run edit permission lifts running write block
// - Output map readable as parameter 915.1-10
// - Input map readable as parameter 916.1-10
// - Channel only slot 0 index 47, class 2
// - Request type 01h means read
// - Drive object must be 01h
// - Attribute 10h reads; count 0 single
// - Start index 0 single, else array element
// - Decode reserved, board, groups A b C d
// - Decode groups F H P U
// - Length field counts frame words
// - Request follows class 2 messaging headers
// - Answer 01h success, 81h any failure
module fbm_mapper (
   input wire logic mclk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [fbm_pkg::APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cyc_out_strobe,
   input wire fbm_pkg::fbm_words_type cyc_out_words,
   output fbm_pkg::fbm_words_type cyc_in_words,
   output logic cyc_in_update,
   output fbm_pkg::fbm_mb_req_type mb_req,
   output logic mb_req_valid,
   input wire logic mb_ack,
   input wire logic [15:0] mb_rdata,
   input wire logic inverter_running,
   input wire logic preq_valid,
   input wire logic preq_first,
   input wire logic preq_last,
   input wire logic [15:0] preq_word,
   input wire logic [15:0] preq_len,
   input wire logic [7:0] preq_slot,
   input wire logic [7:0] preq_index,
   input wire logic preq_class2,
   output fbm_pkg::fbm_pa_type pa_result,
   output logic pa_valid,
   output fbm_pkg::fbm_rsp_type rsp,
   output logic rsp_valid
);
   import fbm_pkg::*;

   // ------------------------------------------------------------
   // APB register slave
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_WRITE = 2'b01,
      SEQ_READ = 2'b10,
      SEQ_DONE = 2'b11
   } fbm_seq_type;

   fbm_seq_type seq_q, seq_d;
   logic [7:0] proto_q, proto_d;
   logic perm_q, perm_d;
   logic blocked_q, blocked_d;
   logic [31:0] prdata_d;
   logic pready_d, pslverr_d;
   logic map_wr, map_hit, setup, access;
   logic [4:0] map_idx;
   logic [11:0] map_ofs;
   fbm_map_type map_q;
   logic blk_set;

   assign setup = psel && !penable;
   assign access = psel && penable && pready;
   assign map_ofs = paddr - MAP_BASE;
   assign map_hit = paddr >= MAP_BASE && paddr <= MAP_END
                    && paddr[1:0] == 2'b00;
   assign map_idx = map_ofs[6:2];
   assign map_wr = access && pwrite && map_hit && !pslverr;

   // Decode in setup, answer in the single access cycle
   always_comb begin
      proto_d = proto_q;
      perm_d = perm_q;
      blocked_d = blocked_q | blk_set;
      prdata_d = prdata;
      pready_d = 1'b0;
      pslverr_d = pslverr;
      if (setup) begin
         pready_d = 1'b1;
         pslverr_d = 1'b0;
         prdata_d = '0;
         if (paddr == CTRL_OFS) begin
            prdata_d = {23'h0, perm_q, proto_q};
         end else if (paddr == STATUS_OFS) begin
            prdata_d[BUSY_BIT] = seq_q != SEQ_IDLE;
            prdata_d[BLOCKED_BIT] = blocked_q;
            prdata_d[RUN_BIT] = inverter_running;
         end else if (map_hit) begin
            prdata_d = {16'h0, map_q[map_idx]};
         end else begin
            pslverr_d = 1'b1;
         end
      end
      if (access && pwrite && !pslverr) begin
         if (paddr == CTRL_OFS) begin
            proto_d = pwdata[7:0];
            perm_d = pwdata[PERM_BIT];
         end else if (paddr == STATUS_OFS
                      && pwdata[BLOCKED_BIT] && !blk_set) begin
            blocked_d = 1'b0;
         end
      end
   end

   // Bus registers
   always_ff @(posedge mclk) begin
      if (reset) begin
         proto_q <= PROTO_RESET;
         perm_q <= 1'b0;
         blocked_q <= 1'b0;
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         proto_q <= proto_d;
         perm_q <= perm_d;
         blocked_q <= blocked_d;
         prdata <= prdata_d;
         pready <= pready_d;
         pslverr <= pslverr_d;
      end
   end

   fbm_map_mem #(.SLOTS(MAP_SLOTS)) u_map (
      .mclk(mclk),
      .reset(reset),
      .wr_en(map_wr),
      .wr_idx(map_idx),
      .wr_data(pwdata[15:0]),
      .map_q(map_q)
   );

   // ------------------------------------------------------------
   // Cyclic exchange sequencer
   // ------------------------------------------------------------
   logic [3:0] slot_q, slot_d;
   fbm_words_type obuf_q, obuf_d, ibuf_q, ibuf_d, cin_d;
   logic skipw_q, skipw_d, upd_d, rv_d;
   fbm_mb_req_type req_d;
   logic [15:0] cur_addr;

   assign cur_addr = (seq_q == SEQ_READ) ? map_q[slot_q + IN_MAP_OFS]
                                         : map_q[slot_q];
   assign blk_set = seq_q == SEQ_IDLE && cyc_out_strobe
                    && proto_q == PROTO_FLEX && inverter_running
                    && !perm_q;

   // Walk ten write slots then ten read slots
   always_comb begin
      seq_d = seq_q;
      slot_d = slot_q;
      obuf_d = obuf_q;
      ibuf_d = ibuf_q;
      cin_d = cyc_in_words;
      skipw_d = skipw_q;
      upd_d = 1'b0;
      rv_d = mb_req_valid;
      req_d = mb_req;
      unique case (seq_q)
         SEQ_IDLE: begin
            if (cyc_out_strobe && proto_q == PROTO_FLEX) begin
               obuf_d = cyc_out_words;
               slot_d = '0;
               skipw_d = inverter_running && !perm_q;
               seq_d = SEQ_WRITE;
            end
         end
         SEQ_WRITE: begin
            if (cur_addr == UNUSED_ADDR || skipw_q) begin
               slot_d = slot_q + 4'h1;
            end else if (!mb_req_valid) begin
               rv_d = 1'b1;
               req_d = '{write: 1'b1, addr: cur_addr,
                         wdata: obuf_q[slot_q]};
            end else if (mb_ack) begin
               rv_d = 1'b0;
               slot_d = slot_q + 4'h1;
            end
            if (slot_d != slot_q && slot_q == LAST_SLOT) begin
               slot_d = '0;
               seq_d = SEQ_READ;
            end
         end
         SEQ_READ: begin
            if (cur_addr == UNUSED_ADDR) begin
               ibuf_d[slot_q] = '0;
               slot_d = slot_q + 4'h1;
            end else if (!mb_req_valid) begin
               rv_d = 1'b1;
               req_d = '{write: 1'b0, addr: cur_addr, wdata: 16'h0};
            end else if (mb_ack) begin
               rv_d = 1'b0;
               ibuf_d[slot_q] = mb_rdata;
               slot_d = slot_q + 4'h1;
            end
            if (slot_d != slot_q && slot_q == LAST_SLOT) begin
               slot_d = '0;
               seq_d = SEQ_DONE;
            end
         end
         SEQ_DONE: begin
            cin_d = ibuf_q;
            upd_d = 1'b1;
            seq_d = SEQ_IDLE;
         end
      endcase
   end

   // Sequencer registers
   always_ff @(posedge mclk) begin
      if (reset) begin
         seq_q <= SEQ_IDLE;
         slot_q <= '0;
         obuf_q <= '0;
         ibuf_q <= '0;
         skipw_q <= 1'b0;
         cyc_in_words <= '0;
         cyc_in_update <= 1'b0;
         mb_req_valid <= 1'b0;
         mb_req <= '0;
      end else begin
         seq_q <= seq_d;
         slot_q <= slot_d;
         obuf_q <= obuf_d;
         ibuf_q <= ibuf_d;
         skipw_q <= skipw_d;
         cyc_in_words <= cin_d;
         cyc_in_update <= upd_d;
         mb_req_valid <= rv_d;
         mb_req <= req_d;
      end
   end

   // ------------------------------------------------------------
   // Parameter read request decoder
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      P_IDLE = 3'b000,
      P_HDR1 = 3'b001,
      P_ATTR = 3'b010,
      P_PNU = 3'b011,
      P_IND = 3'b100
   } fbm_pst_type;

   fbm_pst_type pst_q, pst_d;
   logic [15:0] wcnt_q, wcnt_d, len_q, len_d;
   logic [7:0] ref_q, ref_d, nadr_q, nadr_d, nseen_q, nseen_d;
   logic [7:0] attr_q, attr_d, cnt_q, cnt_d;
   logic [15:0] pnu_q, pnu_d;
   logic ferr_q, ferr_d, chan_ok, take, pav_d, rv2_d, aerr;
   fbm_pa_type pa_d;
   fbm_rsp_type rsp_d;
   fbm_group_type grp;
   logic [9:0] elem;
   logic [16:0] last_el;
   logic [4:0] arr_idx;

   fbm_pnu_decode u_dec (
      .pnu(pnu_q),
      .group(grp),
      .element(elem)
   );

   assign chan_ok = preq_class2 && preq_slot == CHAN_SLOT
                    && preq_index == CHAN_INDEX;
   assign take = preq_valid && (preq_first ? chan_ok : pst_q != P_IDLE);
   assign last_el = {1'b0, preq_word}
                    + {9'h0, (cnt_q == 8'h0) ? 8'h1 : cnt_q} - 17'h1;
   assign arr_idx = preq_word[4:0] - 5'h1
                    + ((pnu_q == IN_MAP_PNU) ? IN_MAP_OFS : 5'h0);

   // One word per accepted beat, results per address triple
   always_comb begin
      pst_d = pst_q;
      wcnt_d = wcnt_q;
      len_d = len_q;
      ref_d = ref_q;
      nadr_d = nadr_q;
      nseen_d = nseen_q;
      attr_d = attr_q;
      cnt_d = cnt_q;
      pnu_d = pnu_q;
      ferr_d = ferr_q;
      pav_d = 1'b0;
      rv2_d = 1'b0;
      pa_d = pa_result;
      rsp_d = rsp;
      aerr = 1'b0;
      if (take) begin
         wcnt_d = wcnt_q + 16'h1;
         if (preq_first) begin
            wcnt_d = 16'h1;
            len_d = preq_len;
            ref_d = preq_word[15:8];
            nseen_d = '0;
            ferr_d = preq_word[7:0] != RT_READ;
            pst_d = P_HDR1;
         end else begin
            unique case (pst_q)
               P_IDLE: begin
                  pst_d = P_IDLE;
               end
               P_HDR1: begin
                  ferr_d = ferr_q || preq_word[15:8] != DO_INVERTER
                           || preq_word[7:0] == 8'h0;
                  nadr_d = preq_word[7:0];
                  pst_d = P_ATTR;
               end
               P_ATTR: begin
                  attr_d = preq_word[15:8];
                  cnt_d = preq_word[7:0];
                  pst_d = P_PNU;
               end
               P_PNU: begin
                  pnu_d = preq_word;
                  pst_d = P_IND;
               end
               P_IND: begin
                  aerr = attr_q != PA_READ_VALUE;
                  aerr = aerr || grp == GRP_NONE;
                  pa_d = '{error: 1'b0, group: grp, pnu: pnu_q,
                           element: elem, count: cnt_q,
                           index: preq_word, value: 16'h0};
                  if (pnu_q == OUT_MAP_PNU || pnu_q == IN_MAP_PNU) begin
                     aerr = aerr || preq_word == 16'h0
                            || last_el > 17'(NUM_WORDS);
                     if (!aerr) begin
                        pa_d.value = map_q[arr_idx];
                     end
                  end
                  pa_d.error = aerr;
                  ferr_d = ferr_q || aerr;
                  nseen_d = nseen_q + 8'h1;
                  pav_d = 1'b1;
                  pst_d = P_ATTR;
               end
               default: begin
                  pst_d = P_IDLE;
               end
            endcase
         end
         if (preq_last) begin
            rv2_d = 1'b1;
            rsp_d.rtype = (ferr_d || wcnt_d != len_d
                           || pst_d != P_ATTR || nseen_d != nadr_d)
                          ? RSP_FAIL : RSP_OK;
            rsp_d.ref_id = ref_d;
            rsp_d.count = nseen_d;
            pst_d = P_IDLE;
         end
      end
   end

   // Decoder registers
   always_ff @(posedge mclk) begin
      if (reset) begin
         pst_q <= P_IDLE;
         wcnt_q <= '0;
         len_q <= '0;
         ref_q <= '0;
         nadr_q <= '0;
         nseen_q <= '0;
         attr_q <= '0;
         cnt_q <= '0;
         pnu_q <= '0;
         ferr_q <= 1'b0;
         pa_valid <= 1'b0;
         pa_result <= '0;
         rsp_valid <= 1'b0;
         rsp <= '0;
      end else begin
         pst_q <= pst_d;
         wcnt_q <= wcnt_d;
         len_q <= len_d;
         ref_q <= ref_d;
         nadr_q <= nadr_d;
         nseen_q <= nseen_d;
         attr_q <= attr_d;
         cnt_q <= cnt_d;
         pnu_q <= pnu_d;
         ferr_q <= ferr_d;
         pa_valid <= pav_d;
         pa_result <= pa_d;
         rsp_valid <= rv2_d;
         rsp <= rsp_d;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   flex_gate_a: assert property (
      seq_q == SEQ_IDLE && seq_d != SEQ_IDLE |-> proto_q == PROTO_FLEX)
      else $error("exchange started outside flexible mode");
   ten_words_a: assert property (
      seq_q == SEQ_WRITE ##1 seq_q == SEQ_READ |-> $past(slot_q) == LAST_SLOT)
      else $error("write phase did not cover ten words");
   write_addr_a: assert property (
      $rose(mb_req_valid) && mb_req.write |->
         mb_req.addr == map_q[slot_q] && mb_req.wdata == obuf_q[slot_q])
      else $error("write request not from its slot");
   read_addr_a: assert property (
      mb_req_valid && mb_ack && !mb_req.write |=>
         ibuf_q[$past(slot_q)] == $past(mb_rdata))
      else $error("read data not stored in its word");
   unused_slot_a: assert property (
      mb_req_valid |-> mb_req.addr != UNUSED_ADDR)
      else $error("transfer issued for unused slot");
   edit_perm_a: assert property (
      $rose(mb_req_valid) && mb_req.write |-> !skipw_q)
      else $error("write issued while run edit blocked");
   map_array_a: assert property (
      pa_valid && !pa_result.error && pa_result.pnu == OUT_MAP_PNU |->
         pa_result.value == map_q[pa_result.index[4:0] - 5'h1])
      else $error("output map value mismatch");
   chan_gate_a: assert property (
      preq_valid && preq_first && !chan_ok |=> $stable(wcnt_q))
      else $error("request taken on wrong channel");
   group_a_a: assert property (
      pa_valid && pa_result.pnu > 16'h03e8 && pa_result.pnu < 16'h07d0
      |-> pa_result.group == GRP_A)
      else $error("group A decode wrong");
   rsp_code_a: assert property (
      rsp_valid && rsp.rtype == RSP_OK |-> !$past(ferr_d))
      else $error("success reported for failed request");
   unused_zero_a: assert property (
      cyc_in_update && map_q[IN_MAP_OFS] == UNUSED_ADDR
      |-> cyc_in_words[0] == 16'h0)
      else $error("unused input word not zero");

   cyc_done_c: cover property (cyc_in_update);
   mb_write_c: cover property (mb_req_valid && mb_req.write && mb_ack);
   rsp_ok_c: cover property (rsp_valid && rsp.rtype == RSP_OK);
   rsp_fail_c: cover property (rsp_valid && rsp.rtype == RSP_FAIL);
endmodule
`default_nettype wire

/* File: fbm_inv_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Inverter register port: one ack per request after a set delay
module fbm_inv_model (
   input wire logic mclk,
   input wire logic reset,
   input wire fbm_pkg::fbm_mb_req_type req,
   input wire logic req_valid,
   input wire logic [2:0] delay,
   output logic ack,
   output logic [15:0] rdata
);
   import fbm_pkg::*;
   logic [2:0] wait_q;
   // Data is inverted on idle cycles and after ack, and held while the delay counts
   always @(posedge mclk) begin
      if (reset) begin
         ack <= 1'b0;
         wait_q <= 3'h0;
         rdata <= 16'h0;
      end else if (ack || !req_valid) begin
         ack <= 1'b0;
         wait_q <= 3'h0;
         rdata <= ~rdata;
      end else if (wait_q == delay) begin
         ack <= 1'b1;
         rdata <= req.addr ^ 16'h5a5a;
      end else begin
         wait_q <= wait_q + 3'h1;
      end
   end
endmodule
`default_nettype wire

/* File: fieldbus_register_mapper_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module fieldbus_register_mapper_tb_top;
   import fbm_pkg::*;
   logic mclk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, err, cyc_out_strobe = 0, cyc_in_update;
   logic mb_req_valid, mb_ack, inverter_running = 0, pa_valid;
   logic preq_valid = 0, preq_first = 0, preq_last = 0, rsp_valid;
   logic preq_class2 = 0;
   logic [15:0] mb_rdata, preq_word = '0, preq_len = 16'h0005;
   logic [7:0] preq_slot = '0, preq_index = 8'h2f;
   logic [2:0] delay = '0;
   fbm_words_type cyc_out_words = '0, cyc_in_words;
   fbm_mb_req_type mb_req;
   fbm_pa_type pa_result, pa_got;
   fbm_rsp_type rsp, rsp_got;
   logic [31:0] wq[$];
   logic [15:0] map[20];
   int fail_count = 0, cmp_count = 0, seed = 32'hc63c;
   int n_rsp = 0, n_exp = 0, n_req = 0;
   int pnus[15] = '{915, 916, 915, 500, 950, 1001, 2999, 3500, 4001,
      6999, 8001, 16500, 21999, 5000, 1001};
   int inds[3] = '{1, 9, 10};

   fbm_mapper uut (.mclk, .reset, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .cyc_out_strobe,
      .cyc_out_words, .cyc_in_words, .cyc_in_update, .mb_req,
      .mb_req_valid, .mb_ack, .mb_rdata, .inverter_running, .preq_valid,
      .preq_first, .preq_last, .preq_word, .preq_len, .preq_slot,
      .preq_index, .preq_class2, .pa_result, .pa_valid, .rsp, .rsp_valid);
   fbm_inv_model inv (.mclk, .reset, .req(mb_req), .req_valid(mb_req_valid),
      .delay, .ack(mb_ack), .rdata(mb_rdata));

   // Clock
   always #20 mclk = ~mclk;

   // Log register writes and parameter answers
   always @(posedge mclk) begin
      if (mb_req_valid && mb_ack && mb_req.write)
         wq.push_back({mb_req.addr, mb_req.wdata});
      if (pa_valid)
         pa_got <= pa_result;
      if (rsp_valid) begin
         rsp_got <= rsp;
         n_rsp++;
      end
   end

   task automatic check(string what, logic [31:0] exp, logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic test_done;
      $display("Compares %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // APB master: setup, then access held until pready
   task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // One cyclic frame against the bench's own map copy
   task automatic cyc(logic go, logic wr_ok);
      int i, n;
      wq.delete();
      @(posedge mclk);
      for (i = 0; i < 10; i++)
         cyc_out_words[i] <= 16'($random(seed));
      cyc_out_strobe <= 1'b1;
      @(posedge mclk);
      cyc_out_strobe <= 1'b0;
      for (i = 0; i < 400 && cyc_in_update !== 1'b1; i++)
         @(posedge mclk);
      check("update", go, cyc_in_update);
      n = 0;
      for (i = 0; i < 10 && go; i++) begin
         check("in", map[10 + i] ? map[10 + i] ^ 16'h5a5a : '0,
            cyc_in_words[i]);
         if (map[i] && wr_ok) begin
            check("wr", {map[i], cyc_out_words[i]}, wq[n]);
            n++;
         end
      end
      check("writes", n, wq.size());
      $display("test cyclic %0d %0d done", go, wr_ok);
   endtask

   // One read request with a single address triple
   task automatic pframe(logic [7:0] rt, int pnu, int start_index, logic c2);
      logic [15:0] w[5];
      int grp, el, ae, v;
      int base[8] = '{1000, 2000, 3000, 4000, 6000, 8000, 16000, 21000};
      n_req++;
      w = '{{8'(n_req), rt}, 16'h0101, 16'h1002, 16'(pnu), 16'(start_index)};
      preq_class2 <= c2;
      for (int i = 0; i < 5; i++) begin
         @(posedge mclk);
         preq_valid <= 1'b1;
         preq_first <= i == 0;
         preq_last <= i == 4;
         preq_word <= w[i];
      end
      @(posedge mclk);
      preq_valid <= 1'b0;
      repeat (3) @(posedge mclk);
      grp = (pnu >= 890 && pnu <= 999) ? 1 : 0;
      el = pnu;
      for (int g = 0; g < 8; g++) begin
         if (pnu > base[g] && pnu <= base[g] + 999) begin
            grp = g + 2;
            el = pnu - base[g];
         end
      end
      ae = grp == 0;
      v = 0;
      if (pnu == 915 || pnu == 916) begin
         ae = start_index == 0 || start_index + 1 > 10;
         v = ae ? 0 : map[(pnu - 915) * 10 + start_index - 1];
      end
      n_exp += c2;
      check("answers", n_exp, n_rsp);
      if (c2) begin
         check("rtype", rt == 1 && !ae ? RSP_OK : RSP_FAIL,
            rsp_got.rtype);
         check("ref", 8'(n_req), rsp_got.ref_id);
         check("count", 1, rsp_got.count);
         check("error", ae, pa_got.error);
         check("group", grp, pa_got.group);
         if (grp)
            check("element", el, pa_got.element);
         if (!ae)
            check("value", v, pa_got.value);
      end
      $display("test parameter %0d done", pnu);
   endtask

   // Watchdog
   initial begin
      #400000;
      fail_count++;
      test_done();
   end

   // Main sequence
   initial begin
      repeat (12) @(posedge mclk);
      reset <= 1'b0;
      for (int i = 0; i < 20; i++) begin
         map[i] = (i % 4 == 2) ? '0 : {8'(8'h10 + i), 8'($random(seed))};
         apb(1'b1, MAP_BASE + 12'(4 * i), {16'h0, map[i]});
      end
      apb(1'b0, 12'hffc, '0);
      check("slverr", 1, err);
      apb(1'b0, MAP_BASE + 12'h04c, '0);
      check("map", {16'h0, map[19]}, rd);
      cyc(1'b0, 1'b1);
      apb(1'b1, CTRL_OFS, 32'h2);
      cyc(1'b1, 1'b1);
      delay <= 3'($random(seed));
      cyc(1'b1, 1'b1);
      inverter_running <= 1'b1;
      cyc(1'b1, 1'b0);
      apb(1'b0, STATUS_OFS, '0);
      check("blocked", 1, rd[1]);
      check("running", 1, rd[RUN_BIT]);
      check("busy", 0, rd[BUSY_BIT]);
      apb(1'b1, STATUS_OFS, 32'h2);
      apb(1'b0, STATUS_OFS, '0);
      check("cleared", 0, rd[BLOCKED_BIT]);
      apb(1'b1, CTRL_OFS, 32'h102);
      apb(1'b0, CTRL_OFS, '0);
      check("ctrl", 32'h102, rd);
      cyc(1'b1, 1'b1);
      for (int i = 0; i < 15; i++)
         pframe(i == 13 ? 8'h02 : 8'h01, pnus[i], i < 3 ? inds[i] : 0,
            i != 14);
      test_done();
   end
endmodule
`default_nettype wire
